// *** bench/gtp_pulse_sink.sv ***
// Model of the timing equipment that consumes the pulse output.
`timescale 1ns/1ps
module gtp_pulse_sink (
  // Clock and reset.
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Pulse line and its polarity.
  input  wire logic        pulse_i,
  input  wire logic        polarity_i,
  // Phase lengths and leading edge count.
  output logic      [15:0] on_o,
  output logic      [15:0] off_o,
  output logic      [15:0] leads_o
);
  logic        active;
  logic        active_q;
  logic [15:0] run_q;
  assign active = pulse_i ~^ polarity_i;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active_q <= 1'b0;
      run_q <= 16'h1;
      on_o <= 16'h0;
      off_o <= 16'h0;
      leads_o <= 16'h0;
    end else if (active == active_q) begin
      run_q <= run_q + 16'h1;
    end else begin
      run_q <= 16'h1;
      active_q <= active;
      if (active_q) on_o <= run_q;
      else off_o <= run_q;
      if (active) leads_o <= leads_o + 16'h1;
    end
  end
endmodule // gtp_pulse_sink

// *** bench/gtp_time_pulse_props.sv ***
// Checker for the time pulse generator ports.
`timescale 1ns/1ps
module gtp_time_pulse_props (
  // Clock, reset and inputs.
  input wire logic                          clock_i,
  input wire logic                          rst_n_i,
  input wire logic                          cfg_wr_i,
  input wire logic [7:0]                    cfg_index_i,
  input wire gtp_pkg::gtp_settings_type     cfg_i,
  input wire logic [15:0]                   rf_delay_ns_i,
  input wire logic [2:0]                    utc_standard_i,
  input wire logic [3:0]                    gnss_enabled_i,
  input wire logic                          external_event_input_i,
  // Outputs watched.
  input wire logic                          one_per_second_pulse_o,
  input wire gtp_pkg::gtp_event_report_type event_time_report_o,
  input wire logic [1:0]                    event_grid_o,
  input wire logic [2:0]                    utc_variant_o,
  input wire logic [15:0]                   rf_delay_ns_o,
  input wire logic                          cfg_ack_o,
  input wire gtp_pkg::gtp_state_type        run_state_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  logic [1:0] live_q;
  logic [2:0] auto_v;
  assign auto_v = gnss_enabled_i[0] ? 3'h1 : gnss_enabled_i[1] ? 3'h2 :
                  gnss_enabled_i[2] ? 3'h3 : 3'h4;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) live_q <= 2'h0;
    else if (live_q != 2'h3) live_q <= live_q + 2'h1;
  end
  property p_ack;
    live_q != 2'h0 |-> cfg_ack_o == $past(cfg_wr_i && cfg_index_i == 8'h00);
  endproperty
  a_ack: assert property (p_ack) else $error("write ack wrong");
  property p_rf;
    live_q != 2'h0 |-> rf_delay_ns_o == $past(rf_delay_ns_i);
  endproperty
  a_rf: assert property (p_rf) else $error("front-end delay wrong");
  property p_egrid;
    event_grid_o != 2'h0;
  endproperty
  a_egrid: assert property (p_egrid) else $error("event grid universal");
  property p_auto;
    utc_standard_i == 3'h0 && gnss_enabled_i != 4'h0 |=> utc_variant_o == $past(auto_v);
  endproperty
  a_auto: assert property (p_auto) else $error("automatic variant wrong");
  property p_manual;
    utc_standard_i != 3'h0 |=> utc_variant_o == $past(utc_standard_i);
  endproperty
  a_manual: assert property (p_manual) else $error("chosen variant wrong");
  property p_idle;
    live_q == 2'h3 && run_state_o == gtp_pkg::GTP_IDLE && !cfg_ack_o && !$past(cfg_ack_o)
      && $past(run_state_o) == gtp_pkg::GTP_IDLE |-> $stable(one_per_second_pulse_o);
  endproperty
  a_idle: assert property (p_idle) else $error("pulse while disabled");
  property p_start;
    cfg_wr_i && cfg_index_i == 8'h00 && cfg_i.enable && cfg_i.grid != 2'h0
      && run_state_o == gtp_pkg::GTP_IDLE |-> ##3 run_state_o == gtp_pkg::GTP_RUN;
  endproperty
  a_start: assert property (p_start) else $error("enable did not start");
  property p_event;
    live_q != 2'h0 && external_event_input_i != $past(external_event_input_i) |=>
      event_time_report_o.valid && event_time_report_o.rising == $past(external_event_input_i);
  endproperty
  a_event: assert property (p_event) else $error("event not stamped");
  c_ack: cover property (cfg_ack_o);
  c_run: cover property (run_state_o == gtp_pkg::GTP_RUN);
  c_event: cover property (event_time_report_o.valid);
endmodule // gtp_time_pulse_props
bind gtp_time_pulse gtp_time_pulse_props i_props (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .cfg_wr_i(cfg_wr_i), .cfg_index_i(cfg_index_i),
  .cfg_i(cfg_i), .rf_delay_ns_i(rf_delay_ns_i), .utc_standard_i(utc_standard_i),
  .gnss_enabled_i(gnss_enabled_i), .external_event_input_i(external_event_input_i),
  .one_per_second_pulse_o(one_per_second_pulse_o), .event_time_report_o(event_time_report_o),
  .event_grid_o(event_grid_o), .utc_variant_o(utc_variant_o), .rf_delay_ns_o(rf_delay_ns_o),
  .cfg_ack_o(cfg_ack_o), .run_state_o(run_state_o));

// *** bench/tb_gtp_time_pulse.sv ***
// Self-checking bench for the time pulse generator.
`timescale 1ns/1ps
module tb_gtp_time_pulse;
  logic                          clock_i, rst_n_i, cfg_wr_i, time_valid_i, utc_params_ok_i;
  logic                          evt, pol, one_per_second_pulse_o, cfg_ack_o, settings_short_o;
  logic [7:0]                    cfg_index_i;
  logic [3:0]                    grid_locked_i, sec_tick_i, gnss_enabled_i;
  logic [2:0]                    utc_standard_i, utc_variant_o;
  logic [1:0]                    event_grid_o;
  logic [15:0]                   rf_delay_ns_i, on_w, off_w, leads_w, n;
  gtp_pkg::gtp_settings_type     cfg_i, s;
  gtp_pkg::gtp_time_type         time_now_i;
  gtp_pkg::gtp_slip_type         slip_i;
  gtp_pkg::gtp_pulse_report_type pulse_time_report_o;
  gtp_pkg::gtp_event_report_type event_time_report_o;
  gtp_pkg::gtp_state_type        run_state_o;
  int                            errors, n_compared, k;
  gtp_time_pulse i_dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .cfg_wr_i(cfg_wr_i), .cfg_index_i(cfg_index_i),
    .cfg_i(cfg_i), .time_valid_i(time_valid_i), .utc_params_ok_i(utc_params_ok_i),
    .grid_locked_i(grid_locked_i), .sec_tick_i(sec_tick_i), .slip_i(slip_i),
    .time_now_i(time_now_i), .rf_delay_ns_i(rf_delay_ns_i), .utc_standard_i(utc_standard_i),
    .gnss_enabled_i(gnss_enabled_i), .external_event_input_i(evt),
    .one_per_second_pulse_o(one_per_second_pulse_o), .pulse_time_report_o(pulse_time_report_o),
    .event_time_report_o(event_time_report_o), .event_grid_o(event_grid_o),
    .utc_variant_o(utc_variant_o), .rf_delay_ns_o(), .cfg_ack_o(cfg_ack_o),
    .settings_short_o(settings_short_o), .run_state_o(run_state_o));
  gtp_pulse_sink i_sink (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .pulse_i(one_per_second_pulse_o),
    .polarity_i(pol), .on_o(on_w), .off_o(off_w), .leads_o(leads_w));
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  task automatic print_verdict();
    if (errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clock_i);
    #10;
  endtask
  task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic cfg_write(input logic [7:0] idx, input gtp_pkg::gtp_settings_type v,
                           input logic ack);
    cfg_index_i = idx;
    cfg_i = v;
    cfg_wr_i = 1'b1;
    tick(1);
    cfg_wr_i = 1'b0;
    cfg_index_i = 8'h00;
    if (ack) pol = v.polarity;
    cmp("cfg_ack_o", ack, cfg_ack_o);
  endtask
  task automatic wait_state(input gtp_pkg::gtp_state_type w);
    int i;
    for (i = 0; i < 300; i++) begin
      if (run_state_o === w) return;
      tick(1);
    end
    $display("mismatch run_state_o expected %0h seen %0h", w, run_state_o);
    errors++;
    print_verdict();
  endtask
  task automatic wait_pulse(input logic v);
    int i;
    for (i = 0; i < 300; i++) begin
      if (one_per_second_pulse_o === v) return;
      tick(1);
    end
    $display("mismatch pulse expected %0h seen %0h", v, one_per_second_pulse_o);
    errors++;
    print_verdict();
  endtask
  task automatic phases(input logic [15:0] on, input logic [15:0] off);
    cmp("on", on, on_w);
    cmp("off", off, off_w);
  endtask
  task automatic align_try(input logic [3:0] lock, input logic exp, input logic [55:0] at);
    grid_locked_i = lock;
    wait_pulse(1'b1);
    wait_pulse(1'b0);
    tick(5);
    sec_tick_i = 4'h2;
    tick(1);
    sec_tick_i = 4'h0;
    cmp("report", 3'h5, {pulse_time_report_o.valid, pulse_time_report_o.grid});
    cmp("report_when", at, pulse_time_report_o.when);
    tick(1);
    cmp("pulse", exp, one_per_second_pulse_o);
  endtask
  function automatic gtp_pkg::gtp_settings_type mk(input logic [1:0] g);
    mk = '0;
    mk.enable = 1'b1;
    mk.is_length = 1'b1;
    mk.polarity = 1'b1;
    mk.grid = g;
    mk.period = 32'h5;
    mk.length = 32'h1;
  endfunction
  initial begin
    {rst_n_i, cfg_wr_i, time_valid_i, utc_params_ok_i, evt, pol} = '0;
    {cfg_index_i, grid_locked_i, sec_tick_i, utc_standard_i} = '0;
    {cfg_i, time_now_i, rf_delay_ns_i, slip_i} = '0;
    gnss_enabled_i = 4'hF;
    errors = 0;
    n_compared = 0;
    repeat (6) @(posedge clock_i);
    #10 rst_n_i = 1'b1;
    s = mk(2'h1);
    cfg_write(8'h00, s, 1'b1);
    wait_state(gtp_pkg::GTP_RUN);
    tick(120);
    phases(16'hA, 16'h28);
    cmp("settings_short_o", 1'b0, settings_short_o);
    s.is_freq = 1'b1;
    s.period = 32'h186A0;
    s.is_length = 1'b0;
    s.length = 32'h4000;
    s.polarity = 1'b0;
    cfg_write(8'h00, s, 1'b1);
    tick(320);
    phases(16'h19, 16'h4B);
    s = mk(2'h1);
    s.use_locked = 1'b1;
    s.period_lock = 32'hA;
    s.length_lock = 32'h3;
    cfg_write(8'h00, s, 1'b1);
    tick(220);
    phases(16'hA, 16'h28);
    time_valid_i = 1'b1;
    tick(320);
    phases(16'h1E, 16'h46);
    s.enable = 1'b0;
    cfg_write(8'h01, s, 1'b0);
    tick(210);
    phases(16'h1E, 16'h46);
    cfg_write(8'h00, s, 1'b1);
    tick(10);
    n = leads_w;
    tick(200);
    cmp("leads", n, leads_w);
    cmp("pulse", 1'b0, one_per_second_pulse_o);
    s = mk(2'h1);
    s.align_sec = 1'b1;
    time_now_i = {32'h5, 24'h1};
    cfg_write(8'h00, s, 1'b1);
    wait_state(gtp_pkg::GTP_RUN);
    align_try(4'h0, 1'b0, {32'h5, 24'h23});
    align_try(4'h2, 1'b1, {32'h5, 24'h1});
    s.enable = 1'b0;
    cfg_write(8'h00, s, 1'b1);
    tick(5);
    s = mk(2'h0);
    cfg_write(8'h00, s, 1'b1);
    tick(20);
    cmp("state", gtp_pkg::GTP_WAIT_UTC, run_state_o);
    cmp("pulse", 1'b0, one_per_second_pulse_o);
    cmp("event_grid_o", 2'h1, event_grid_o);
    utc_params_ok_i = 1'b1;
    wait_state(gtp_pkg::GTP_RUN);
    for (k = 1; k < 4; k++) begin
      s.grid = k[1:0];
      cfg_write(8'h00, s, 1'b1);
      tick(2);
      cmp("event_grid_o", k, event_grid_o);
    end
    for (k = 1; k < 5; k++) begin
      utc_standard_i = k[2:0];
      tick(2);
      cmp("utc_variant_o", k, utc_variant_o);
    end
    utc_standard_i = 3'h0;
    gnss_enabled_i = 4'hC;
    tick(2);
    cmp("utc_variant_o", 3'h3, utc_variant_o);
    s.cable_delay_ns = 16'hC8;
    s.user_delay_ns = 16'h32;
    rf_delay_ns_i = 16'h32;
    cfg_write(8'h00, s, 1'b1);
    time_now_i = {32'h5, 24'h1};
    evt = 1'b1;
    tick(1);
    cmp("rise", 5'h1B, event_time_report_o[132:128]);
    cmp("marks", 16'h1, event_time_report_o.marks);
    cmp("rise_time", {32'h4, 24'h98967E}, event_time_report_o.rise_time);
    evt = 1'b0;
    tick(1);
    cmp("fall", 5'h17, event_time_report_o[132:128]);
    cmp("fall_time", {32'h4, 24'h98967E}, event_time_report_o.fall_time);
    s.freq_lock = 1'b1;
    cfg_write(8'h00, s, 1'b1);
    tick(60);
    wait_pulse(1'b1);
    wait_pulse(1'b0);
    slip_i = 2'h1;
    tick(1);
    slip_i = 2'h0;
    wait_pulse(1'b1);
    tick(1);
    phases(16'hA, 16'h29);
    wait_pulse(1'b0);
    slip_i = 2'h2;
    tick(1);
    slip_i = 2'h0;
    wait_pulse(1'b1);
    tick(1);
    phases(16'hA, 16'h27);
    s.is_length = 1'b0;
    s.length = 32'h1;
    cfg_write(8'h00, s, 1'b1);
    tick(1);
    cmp("settings_short_o", 1'b1, settings_short_o);
    print_verdict();
  end
endmodule // tb_gtp_time_pulse

// *** hw/gtp_cfg.svh ***
// Constants for the time pulse generator and event time-stamp block.
// Overview of operation
// - Pulses appear on the output only while the enable setting is set.
// - Primary period is used unless locked mode is enabled and time is valid.
// - With valid time and locked mode enabled, the locked period is used.
// - With valid time and locked mode enabled, the locked length is used.
// - The width field is an absolute on time or a ratio of period.
// - The alternate set applies once time is valid, so a pulse may be disabled.
// - The frequency flag makes the period field a frequency in hertz.
// - The length flag makes the width field a duration, otherwise a duty ratio.
// - With alignment set, edges land on whole seconds of the selected grid.
// - Alignment holds only while locked; unlocked the configured rate continues.
// - Polarity set gives a rising leading edge, clear gives a falling one.
// - Grid 0 universal, 1 US, 2 Russian, 3 Chinese time; reports use it too.
// - The frequency lock flag disciplines the period from satellite rate steps.
// - The pulse width is clamped so it never exceeds the current period.
// - Cable, front-end and user delays shift the pulse earlier.
// - The front-end group delay is read only and cannot be written.
// - On the universal grid, output waits for time conversion parameters.
// - Automatic universal variant prefers US, Russian, Chinese, then European.
// - Events share the output base; universal output makes events US time.
// - Each event edge is time-stamped with the same delay compensation.
// - Pulse reports come at 1 Hz and always describe the next pulse.
`ifndef GTP_CFG_SVH
`define GTP_CFG_SVH
`define GTP_CLK_HZ        32'h0098_9680
`define GTP_TICK_NS       32'h0000_0064
`define GTP_TICKS_PER_US  32'h0000_000A
`define GTP_TICKS_PER_SEC 40'h00_0098_9680
`define GTP_MIN_PHASE_NS  32'h0000_0032
`define GTP_MIN_PHASE_CYC ((`GTP_MIN_PHASE_NS + `GTP_TICK_NS - 32'h1) / `GTP_TICK_NS)
`define GTP_OUT_INDEX     8'h00
`define GTP_RATIO_SHIFT   16
`define GTP_GRID_UTC      2'h0
`define GTP_GRID_GPS      2'h1
`define GTP_GRID_GLO      2'h2
`define GTP_GRID_BDS      2'h3
`define GTP_UTC_AUTO      3'h0
`define GTP_UTC_USNO      3'h1
`define GTP_UTC_SU        3'h2
`define GTP_UTC_NTSC      3'h3
`define GTP_UTC_EU        3'h4
`define GTP_SYS_GPS       0
`define GTP_SYS_GLO       1
`define GTP_SYS_BDS       2
`define GTP_SYS_GAL       3
`endif

// *** hw/gtp_pkg.sv ***
// Types shared by the time pulse generator and its bench.
package gtp_pkg;
  typedef struct packed {
    logic        enable;
    logic        use_locked;
    logic        is_freq;
    logic        is_length;
    logic        align_sec;
    logic        polarity;
    logic        freq_lock;
    logic [1:0]  grid;
    logic [31:0] period;
    logic [31:0] period_lock;
    logic [31:0] length;
    logic [31:0] length_lock;
    logic [15:0] cable_delay_ns;
    logic [15:0] user_delay_ns;
  } gtp_settings_type;
  typedef struct packed {
    logic [31:0] secs;
    logic [23:0] ticks;
  } gtp_time_type;
  typedef struct packed {
    logic         valid;
    logic [1:0]   grid;
    gtp_time_type when;
    logic [7:0]   qerr_ns;
  } gtp_pulse_report_type;
  typedef struct packed {
    logic         valid;
    logic         rising;
    logic         falling;
    logic [1:0]   grid;
    logic [15:0]  marks;
    gtp_time_type rise_time;
    gtp_time_type fall_time;
  } gtp_event_report_type;
  typedef struct packed {
    logic add;
    logic drop;
  } gtp_slip_type;
  typedef enum logic [1:0] {GTP_IDLE, GTP_WAIT_UTC, GTP_RUN} gtp_state_type;
endpackage

// *** hw/gtp_time_pulse.sv ***
// Time pulse generator with delay compensation and external event time-stamping.
`timescale 1ns/1ps
`include "gtp_cfg.svh"
module gtp_time_pulse (
  // Clock and reset.
  input  wire logic                         clock_i,
  input  wire logic                         rst_n_i,
  // Settings write port.
  input  wire logic                         cfg_wr_i,
  input  wire logic [7:0]                   cfg_index_i,
  input  wire gtp_pkg::gtp_settings_type    cfg_i,
  // Time engine status.
  input  wire logic                         time_valid_i,
  input  wire logic                         utc_params_ok_i,
  input  wire logic [3:0]                   grid_locked_i,
  input  wire logic [3:0]                   sec_tick_i,
  input  wire gtp_pkg::gtp_slip_type        slip_i,
  input  wire gtp_pkg::gtp_time_type        time_now_i,
  input  wire logic [15:0]                  rf_delay_ns_i,
  // Universal time variant choice.
  input  wire logic [2:0]                   utc_standard_i,
  input  wire logic [3:0]                   gnss_enabled_i,
  // External event input.
  input  wire logic                         external_event_input_i,
  // Pulse output and reports.
  output logic                              one_per_second_pulse_o,
  output gtp_pkg::gtp_pulse_report_type     pulse_time_report_o,
  output gtp_pkg::gtp_event_report_type     event_time_report_o,
  output logic [1:0]                        event_grid_o,
  output logic [2:0]                        utc_variant_o,
  output logic [15:0]                       rf_delay_ns_o,
  output logic                              cfg_ack_o,
  output logic                              settings_short_o,
  output gtp_pkg::gtp_state_type            run_state_o
);

  // Settings shadow, written only through selector zero.
  gtp_pkg::gtp_settings_type cfg_q;
  wire                       cfg_hit;

  assign cfg_hit = cfg_wr_i & (cfg_index_i == `GTP_OUT_INDEX);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_q     <= '0;
      cfg_ack_o <= 1'b0;
    end else begin
      if (cfg_hit) begin
        cfg_q <= cfg_i;
      end
      cfg_ack_o <= cfg_hit;
    end
  end

  // Selection of the primary or locked setting pair.
  wire        sel_lock;
  wire [31:0] sel_period;
  wire [31:0] sel_length;

  assign sel_lock   = cfg_q.use_locked & time_valid_i;
  assign sel_period = sel_lock ? cfg_q.period_lock : cfg_q.period;
  assign sel_length = sel_lock ? cfg_q.length_lock : cfg_q.length;

  // Period and width in clock ticks.
  wire [31:0] freq_ticks;
  wire [31:0] per_ticks;
  wire [31:0] period_ticks;
  wire [48:0] ratio_prod;
  wire [31:0] ratio_ticks;
  wire [31:0] len_ticks;
  wire [31:0] width_raw;
  wire [31:0] width_ticks;

  assign freq_ticks   = (sel_period == 32'h0) ? 32'h0 : (`GTP_CLK_HZ / sel_period);
  assign per_ticks    = 32'(sel_period * `GTP_TICKS_PER_US);
  assign period_ticks = cfg_q.is_freq ? freq_ticks : per_ticks;
  assign ratio_prod   = 49'(period_ticks * sel_length[16:0]);
  assign ratio_ticks  = ratio_prod[`GTP_RATIO_SHIFT +: 32];
  assign len_ticks    = 32'(sel_length * `GTP_TICKS_PER_US);
  assign width_raw    = cfg_q.is_length ? len_ticks : ratio_ticks;
  assign width_ticks  = (width_raw > period_ticks) ? period_ticks : width_raw;

  // Delay compensation moves the leading edge earlier than the nominal boundary.
  wire [17:0] comp_ns;
  wire [17:0] comp_ticks;
  wire [7:0]  comp_frac_ns;
  wire [31:0] start_ticks;

  assign comp_ns      = 18'(cfg_q.cable_delay_ns) + 18'(rf_delay_ns_i) +
                        18'(cfg_q.user_delay_ns);
  assign comp_ticks   = 18'(comp_ns / 18'(`GTP_TICK_NS));
  assign comp_frac_ns = 8'(comp_ns % 18'(`GTP_TICK_NS));
  assign start_ticks  = (32'(comp_ticks) >= period_ticks) ? 32'h0 :
                        ((comp_ticks == 18'h0) ? 32'h0 :
                        (period_ticks - 32'(comp_ticks)));

  // Run state.
  gtp_pkg::gtp_state_type state_q;
  gtp_pkg::gtp_state_type state_d;
  wire                    utc_blocked;

  assign utc_blocked = (cfg_q.grid == `GTP_GRID_UTC) & ~utc_params_ok_i;

  always_comb begin
    state_d = state_q;
    case (state_q)
      gtp_pkg::GTP_IDLE: begin
        if (cfg_q.enable) begin
          state_d = utc_blocked ? gtp_pkg::GTP_WAIT_UTC : gtp_pkg::GTP_RUN;
        end
      end
      gtp_pkg::GTP_WAIT_UTC: begin
        if (!cfg_q.enable) begin
          state_d = gtp_pkg::GTP_IDLE;
        end else if (!utc_blocked) begin
          state_d = gtp_pkg::GTP_RUN;
        end
      end
      gtp_pkg::GTP_RUN: begin
        if (!cfg_q.enable) begin
          state_d = gtp_pkg::GTP_IDLE;
        end else if (utc_blocked) begin
          state_d = gtp_pkg::GTP_WAIT_UTC;
        end
      end
      default: begin
        state_d = gtp_pkg::GTP_IDLE;
      end
    endcase
  end

  // Period counter with rate discipline and second alignment.
  logic [31:0] phase_q;
  logic [31:0] phase_d;
  logic [31:0] period_q;
  logic [31:0] width_q;
  logic [31:0] start_q;
  wire         running;
  wire         entering;
  wire [1:0]   step;
  wire [32:0]  phase_sum;
  wire         wrap;
  wire         align_hit;
  wire         load_now;

  assign running   = (state_q == gtp_pkg::GTP_RUN);
  assign entering  = (state_d == gtp_pkg::GTP_RUN) & ~running;
  assign step      = (cfg_q.freq_lock & time_valid_i & slip_i.drop) ? 2'h0 :
                     ((cfg_q.freq_lock & time_valid_i & slip_i.add) ? 2'h2 : 2'h1);
  assign phase_sum = 33'(phase_q) + 33'(step);
  assign wrap      = (phase_sum >= 33'(period_q));
  assign align_hit = cfg_q.align_sec & grid_locked_i[cfg_q.grid] &
                     sec_tick_i[cfg_q.grid];
  assign load_now  = entering | align_hit | wrap;

  always_comb begin
    phase_d = phase_q;
    if (entering | align_hit) begin
      phase_d = 32'h0;
    end else if (running) begin
      if (period_q == 32'h0) begin
        phase_d = 32'h0;
      end else if (wrap) begin
        phase_d = 32'(phase_sum - 33'(period_q));
      end else begin
        phase_d = phase_sum[31:0];
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q  <= gtp_pkg::GTP_IDLE;
      phase_q  <= 32'h0;
      period_q <= 32'h0;
      width_q  <= 32'h0;
      start_q  <= 32'h0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      if (load_now) begin
        period_q <= period_ticks;
        width_q  <= width_ticks;
        start_q  <= start_ticks;
      end
    end
  end

  // Width comparison relative to the compensated leading edge.
  wire [31:0] rel_phase;
  wire [31:0] until_start;
  wire        pulse_on;
  wire        short_high;
  wire        short_low;

  assign rel_phase   = (phase_q >= start_q) ? (phase_q - start_q) :
                       (phase_q + period_q - start_q);
  assign until_start = (rel_phase == 32'h0) ? 32'h0 : (period_q - rel_phase);
  assign pulse_on    = running & (period_q != 32'h0) & (rel_phase < width_q);
  assign short_high  = (sel_length != 32'h0) & (width_ticks < `GTP_MIN_PHASE_CYC);
  assign short_low   = (width_ticks != period_ticks) &
                       ((period_ticks - width_ticks) < `GTP_MIN_PHASE_CYC);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      one_per_second_pulse_o <= 1'b0;
      settings_short_o       <= 1'b0;
      run_state_o            <= gtp_pkg::GTP_IDLE;
      rf_delay_ns_o          <= 16'h0;
    end else begin
      one_per_second_pulse_o <= pulse_on ~^ cfg_q.polarity;
      settings_short_o       <= cfg_q.enable & (short_high | short_low);
      run_state_o            <= state_q;
      rf_delay_ns_o          <= rf_delay_ns_i;
    end
  end

  // Pulse time report: once per second, always the upcoming pulse.
  wire [39:0] next_sum;
  wire [31:0] next_secs;
  wire [23:0] next_ticks;
  wire        report_tick;

  assign next_sum    = 40'(time_now_i.ticks) + 40'(align_hit ? start_ticks : until_start) +
                       40'(comp_ticks);
  assign next_secs   = time_now_i.secs + 32'(next_sum / `GTP_TICKS_PER_SEC);
  assign next_ticks  = 24'(next_sum % `GTP_TICKS_PER_SEC);
  assign report_tick = sec_tick_i[cfg_q.grid] & running;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pulse_time_report_o <= '0;
    end else begin
      pulse_time_report_o.valid <= report_tick;
      if (report_tick) begin
        pulse_time_report_o.grid       <= cfg_q.grid;
        pulse_time_report_o.when.secs  <= next_secs;
        pulse_time_report_o.when.ticks <= next_ticks;
        pulse_time_report_o.qerr_ns    <= comp_frac_ns;
      end
    end
  end

  // Automatic universal time variant selection.
  wire [2:0] auto_variant;
  wire [2:0] utc_variant;

  assign auto_variant = gnss_enabled_i[`GTP_SYS_GPS] ? `GTP_UTC_USNO :
                        gnss_enabled_i[`GTP_SYS_GLO] ? `GTP_UTC_SU :
                        gnss_enabled_i[`GTP_SYS_BDS] ? `GTP_UTC_NTSC :
                        `GTP_UTC_EU;
  assign utc_variant  = (utc_standard_i == `GTP_UTC_AUTO) ? auto_variant : utc_standard_i;

  // External event time-stamping.
  logic         event_q;
  wire          ev_rise;
  wire          ev_fall;
  wire [1:0]    ev_grid;
  wire [23:0]   ev_ticks;
  wire [31:0]   ev_secs;
  gtp_pkg::gtp_time_type ev_stamp;

  assign ev_rise  = external_event_input_i & ~event_q;
  assign ev_fall  = ~external_event_input_i & event_q;
  assign ev_grid  = (cfg_q.grid == `GTP_GRID_UTC) ? `GTP_GRID_GPS : cfg_q.grid;
  assign ev_ticks = (time_now_i.ticks >= 24'(comp_ticks)) ?
                    (time_now_i.ticks - 24'(comp_ticks)) :
                    24'(40'(time_now_i.ticks) + `GTP_TICKS_PER_SEC - 40'(comp_ticks));
  assign ev_secs  = (time_now_i.ticks >= 24'(comp_ticks)) ? time_now_i.secs :
                    (time_now_i.secs - 32'h1);
  assign ev_stamp = '{secs: ev_secs, ticks: ev_ticks};

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      event_q             <= 1'b0;
      event_time_report_o <= '0;
      event_grid_o        <= `GTP_GRID_GPS;
      utc_variant_o       <= `GTP_UTC_USNO;
    end else begin
      event_q                     <= external_event_input_i;
      event_grid_o                <= ev_grid;
      utc_variant_o               <= utc_variant;
      event_time_report_o.valid   <= ev_rise | ev_fall;
      event_time_report_o.rising  <= ev_rise;
      event_time_report_o.falling <= ev_fall;
      if (ev_rise) begin
        event_time_report_o.rise_time <= ev_stamp;
        event_time_report_o.marks     <= event_time_report_o.marks + 16'h1;
        event_time_report_o.grid      <= ev_grid;
      end
      if (ev_fall) begin
        event_time_report_o.fall_time <= ev_stamp;
        event_time_report_o.grid      <= ev_grid;
      end
    end
  end

endmodule // gtp_time_pulse
